// *** fspc_top.v ***
// fspc_top.v: flash self programming controller with an APB register slave.
// assumes an on-chip cpu as APB master, stalled by cpu_stall_o, whose
// interrupt controller honours irq_hold_o.
//
// Summary of operation
// - batch-erase security rejects every later erase
// - secured write cannot change programmed bits
// - security setting applies at next mode entry
// - cpu stalled while a command runs
// - interrupts held pending until mode exits
// - controller never touches ram during commands
// - block erase leaves every byte blank
// - pins held as in halt mode
// - reset mid-command leaves contents unguaranteed
`timescale 1ns/1ns
`default_nettype none
`include "fspc_map.vh"
module fspc_top (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        cpu_stall_o,
  output wire        irq_hold_o,
  output wire        pin_halt_hold_o,
  output wire        ram_req_o
);
  // ************************************************************
  // states
  // ************************************************************
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_READ  = 2'd1;
  localparam [1:0] ST_RUN   = 2'd2;

  reg         spm_q;
  reg  [7:0]  addr_hi_q;
  reg  [7:0]  addr_q;
  reg  [7:0]  data_q;
  reg         sec_pend_q;
  reg         sec_act_q;
  reg         err_q;
  reg         addr_err_q;
  reg  [1:0]  state_q;
  reg  [1:0]  cmd_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  cnt_q;
  reg  [7:0]  rd_q;
  reg  [31:0] prdata_q;
  reg         ack_q;
  wire [7:0]  arr_rdata;
  reg         arr_we;
  reg  [7:0]  arr_wdata;

  wire setup    = psel & ~penable;
  wire wr_setup = setup & pwrite;
  wire busy     = (state_q != ST_IDLE);
  wire mapped   = (paddr == `FSPC_OFF_MODE) || (paddr == `FSPC_OFF_ADDR) ||
                  (paddr == `FSPC_OFF_DATA) || (paddr == `FSPC_OFF_CMD) ||
                  (paddr == `FSPC_OFF_STATUS) || (paddr == `FSPC_OFF_SECURITY);
  wire [7:0] blk_first = {ptr_q[7:`FSPC_BLK_BITS], 4'h0};
  wire [7:0] blk_last  = {ptr_q[7:`FSPC_BLK_BITS], 4'hF};

  // ************************************************************
  // apb slave: answers in the access phase; busy stretches via pready
  // ************************************************************
  // stall holds bus
  assign pready  = psel & penable & ~busy;
  assign pslverr = psel & penable & ~busy & ~mapped;
  assign prdata  = prdata_q;

  assign cpu_stall_o     = busy;
  assign irq_hold_o      = spm_q;
  assign pin_halt_hold_o = spm_q;
  assign ram_req_o       = 1'b0;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
      ack_q    <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      if (setup && !pwrite) begin
        case (paddr)
          `FSPC_OFF_MODE:     prdata_q <= {31'h0000_0000, spm_q};
          `FSPC_OFF_ADDR:     prdata_q <= {16'h0000, addr_hi_q, addr_q};
          `FSPC_OFF_DATA:     prdata_q <= {24'h00_0000, rd_q};
          `FSPC_OFF_STATUS:   prdata_q <= {28'h000_0000, addr_err_q, sec_act_q,
                                           err_q, busy};
          `FSPC_OFF_SECURITY: prdata_q <= {31'h0000_0000, sec_pend_q};
          default:            prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // registers and command sequencer
  // ************************************************************
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      spm_q      <= 1'b0;
      addr_hi_q  <= 8'h00;
      addr_q     <= 8'h00;
      data_q     <= 8'h00;
      sec_pend_q <= 1'b0;
      sec_act_q  <= 1'b0;
      err_q      <= 1'b0;
      addr_err_q <= 1'b0;
      // cut command dropped, cells left as is
      state_q    <= ST_IDLE;
      cmd_q      <= 2'd0;
      ptr_q      <= 8'h00;
      cnt_q      <= 8'h00;
      rd_q       <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_setup) begin
            case (paddr)
              `FSPC_OFF_MODE: begin
                spm_q <= pwdata[`FSPC_MODE_SPM_BIT];
                if (pwdata[`FSPC_MODE_SPM_BIT] && !spm_q) begin
                  sec_act_q <= sec_pend_q;
                end
              end
              `FSPC_OFF_ADDR: begin
                addr_q    <= pwdata[7:0];
                addr_hi_q <= pwdata[15:8];
              end
              `FSPC_OFF_DATA: data_q <= pwdata[7:0];
              // once set, the security setting is permanent until reset
              `FSPC_OFF_SECURITY: sec_pend_q <= sec_pend_q | pwdata[0];
              `FSPC_OFF_CMD: begin
                if (spm_q && pwdata[1:0] != 2'd0) begin
                  err_q      <= 1'b0;
                  addr_err_q <= 1'b0;
                  // upper pointer bits not cleared: command refused
                  if (addr_hi_q[7:4] != 4'h0) begin
                    addr_err_q <= 1'b1;
                  end else if (pwdata[1:0] == `FSPC_CMD_ERASE && sec_act_q) begin
                    err_q <= 1'b1;
                  end else begin
                    cmd_q   <= pwdata[1:0];
                    ptr_q   <= addr_q;
                    cnt_q   <= 8'h00;
                    state_q <= ST_READ;
                  end
                end
              end
              default: ;
            endcase
          end
        end
        ST_READ: begin
          // array read data valid; now run timed program or erase
          if (cmd_q == `FSPC_CMD_ERASE) begin
            ptr_q <= blk_first;
          end
          if (cmd_q == `FSPC_CMD_VERIFY) begin
            rd_q    <= arr_rdata;
            state_q <= ST_IDLE;
          end else if (cmd_q == `FSPC_CMD_WRITE && sec_act_q &&
                       (arr_rdata != `FSPC_BLANK) && (data_q != arr_rdata)) begin
            err_q   <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_q <= cnt_q + 8'd1;
          if (cmd_q == `FSPC_CMD_WRITE) begin
            if (cnt_q == `FSPC_WRITE_CYC - 1) begin
              state_q <= ST_IDLE;
            end
          end else if (cnt_q == `FSPC_ERASE_CYC - 1) begin
            cnt_q <= 8'h00;
            if (ptr_q == blk_last) begin
              state_q <= ST_IDLE;
            end else begin
              ptr_q <= ptr_q + 8'd1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // array port: programming writes data_q as given, erase writes blank
  // ************************************************************
  always @* begin
    arr_we    = 1'b0;
    arr_wdata = `FSPC_BLANK;
    if (state_q == ST_RUN) begin
      if (cmd_q == `FSPC_CMD_WRITE) begin
        arr_we    = (cnt_q == `FSPC_WRITE_CYC - 1);
        arr_wdata = data_q;
      end else begin
        arr_we    = (cnt_q == `FSPC_ERASE_CYC - 1);
        arr_wdata = `FSPC_BLANK;
      end
    end
  end

  fspc_flash_array u_array (
    .clk_sys (clk_sys),
    .we      (arr_we),
    .addr    ((state_q == ST_IDLE) ? addr_q : ptr_q),
    .wdata   (arr_wdata),
    .rdata   (arr_rdata)
  );
endmodule // fspc_top
`default_nettype wire

// *** fspc_map.vh ***
// fspc_map.vh: register offsets, field positions, reset values and timing counts
// for the flash self programming controller; included by both design files.
`ifndef FSPC_MAP_VH
`define FSPC_MAP_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define FSPC_OFF_MODE      12'h000
`define FSPC_OFF_ADDR      12'h004
`define FSPC_OFF_DATA      12'h008
`define FSPC_OFF_CMD       12'h00C
`define FSPC_OFF_STATUS    12'h010
`define FSPC_OFF_SECURITY  12'h014
// ************************************************************
// fields
// ************************************************************
`define FSPC_MODE_SPM_BIT  0
`define FSPC_CMD_WRITE     2'h1
`define FSPC_CMD_ERASE     2'h2
`define FSPC_CMD_VERIFY    2'h3
`define FSPC_ST_BUSY       0
`define FSPC_ST_ERR        1
`define FSPC_ST_SEC_ACT    2
`define FSPC_ST_ADDR_ERR   3
// ************************************************************
// reset values and sizes
// ************************************************************
`define FSPC_BLANK         8'hFF
`define FSPC_AW            8
`define FSPC_DEPTH         256
`define FSPC_BLK_BITS      4
// ************************************************************
// timing: program and erase times, one cycle of clk_sys is 40 ns
// ************************************************************
`define FSPC_CLK_NS        40
`define FSPC_WRITE_NS      400
`define FSPC_ERASE_NS      1600
`define FSPC_WRITE_CYC     (`FSPC_WRITE_NS / `FSPC_CLK_NS)
`define FSPC_ERASE_CYC     (`FSPC_ERASE_NS / `FSPC_CLK_NS)
`endif

// *** fspc_flash_array.v ***
// fspc_flash_array.v: model of the flash cell array, one byte per word.
// assumes the controller alone drives it; read data come out of a register.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_map.vh"
module fspc_flash_array (
  input  wire       clk_sys,
  input  wire       we,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata
);
  reg [7:0] mem [0:`FSPC_DEPTH-1];
  integer   i;

  // contents start blank; flash keeps them through a device reset
  initial begin
    for (i = 0; i < `FSPC_DEPTH; i = i + 1) begin
      mem[i] = `FSPC_BLANK;
    end
  end

  always @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // fspc_flash_array
`default_nettype wire

// *** fspc_cpu_model.sv ***
// fspc_cpu_model.sv: cpu side of the controller, an APB master
// assumes fspc_top as slave on clk_sys; cpu waits out stalls
`timescale 1ns/1ns
`default_nettype none
module fspc_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        pready,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // firmware blocks here while a command runs
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // pready is sampled at the rising edge; request released only after it
    @(posedge clk_sys);
    while (!pready) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // interrupts already masked by firmware; mode bit set to one
  task automatic enter_mode;
    xfer(1'b1, 12'h000, 32'h0000_0001);
    // settle time of 16 us before any halt, at 40 ns a cycle
    repeat (16000 / 40) @(posedge clk_sys);
  endtask
  task automatic run_cmd(input logic [7:0] a, input logic [1:0] c);
    xfer(1'b1, 12'h004, {24'h00_0000, a});
    xfer(1'b1, 12'h00C, {30'h0000_0000, c});
  endtask
endmodule // fspc_cpu_model
`default_nettype wire

// *** fspc_top_assertions.sv ***
// fspc_top_assertions.sv: port checker for fspc_top
// assumes one clock domain; bound below onto every fspc_top
`timescale 1ns/1ns
`default_nettype none
module fspc_chk (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_stall_o,
  input wire logic        irq_hold_o,
  input wire logic        pin_halt_hold_o,
  input wire logic        ram_req_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire mode_wr = psel && !penable && pwrite && paddr == 12'h000;
  wire cmd_wr  = psel && !penable && pwrite && paddr == 12'h00C;
  property p_no_ram; !ram_req_o; endproperty
  a_no_ram: assert property (p_no_ram) else $error("ram touched");
  property p_stall_ready; cpu_stall_o |-> !pready; endproperty
  a_stall_ready: assert property (p_stall_ready) else $error("ready in cmd");
  property p_stall_start; $rose(cpu_stall_o) |-> $past(cmd_wr); endproperty
  a_stall_start: assert property (p_stall_start) else $error("stray stall");
  property p_stall_end; cpu_stall_o |-> ##[1:700] !cpu_stall_o; endproperty
  a_stall_end: assert property (p_stall_end) else $error("stall stuck");
  property p_stall_mode; cpu_stall_o |-> irq_hold_o; endproperty
  a_stall_mode: assert property (p_stall_mode) else $error("irq open in cmd");
  property p_pins; pin_halt_hold_o == irq_hold_o; endproperty
  a_pins: assert property (p_pins) else $error("pins not halted");
  property p_hold_on; $rose(irq_hold_o) |-> $past(mode_wr && pwdata[0]); endproperty
  a_hold_on: assert property (p_hold_on) else $error("hold without entry");
  property p_hold_off; $fell(irq_hold_o) |-> $past(mode_wr && !pwdata[0]); endproperty
  a_hold_off: assert property (p_hold_off) else $error("hold left early");
  c_cmd: cover property ($rose(cpu_stall_o));
  c_exit: cover property ($fell(irq_hold_o));
  c_err: cover property (pslverr && pready);
endmodule // fspc_chk
bind fspc_top fspc_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_stall_o(cpu_stall_o), .irq_hold_o(irq_hold_o),
  .pin_halt_hold_o(pin_halt_hold_o), .ram_req_o(ram_req_o));
`default_nettype wire

// *** fspc_top_tb_top.sv ***
// fspc_top_tb_top.sv: self-checking bench for fspc_top
// assumes the cpu model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "fspc_map.vh"
module fspc_top_tb_top;
  logic             clk_sys;
  logic             arst_n;
  wire logic        psel, penable, pwrite, pready, pslverr;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic        cpu_stall, irq_hold, pin_hold, ram_req;
  int               err_count = 0;
  int               compares = 0;
  int               cycles = 0;
  int               seed;
  logic [32:0]      expq[$];
  logic [7:0]       byte_v;
  fspc_cpu_model cpu (.clk_sys(clk_sys), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  fspc_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_stall_o(cpu_stall), .irq_hold_o(irq_hold),
    .pin_halt_hold_o(pin_hold), .ram_req_o(ram_req));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // level outputs, looked at once the transfer that moves them has ended
  task automatic chk_pin(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask
  // the read note is queued before the bus cycle starts
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    cpu.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic vfy(input logic [7:0] a, input logic [7:0] v);
    cpu.run_cmd(a, `FSPC_CMD_VERIFY);
    rd(12'h008, {25'h000_0000, v});
  endtask
  // read data are taken at the rising edge that samples pready high
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) chk("read", expq.pop_front(), {pslverr, prdata});
  end
  // ceiling well above two erases of 641 cycles, two 400-cycle waits and the bus traffic
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      wrap_up();
    end
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    arst_n = 1'b0;
    seed = 19;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    byte_v = 8'($random(seed));
    cpu.enter_mode();
    chk_pin("irq_hold", 1'b1, irq_hold);
    chk_pin("pin_hold", 1'b1, pin_hold);
    cpu.xfer(1'b1, 12'h008, {24'h00_0000, byte_v});
    cpu.run_cmd(8'h21, `FSPC_CMD_WRITE);
    vfy(8'h21, byte_v);
    chk_pin("cpu_stall", 1'b0, cpu_stall);
    cpu.run_cmd(8'h2B, `FSPC_CMD_ERASE);
    vfy(8'h21, `FSPC_BLANK);
    repeat (3) vfy({4'h2, 4'($random(seed))}, `FSPC_BLANK);
    cpu.xfer(1'b1, 12'h004, 32'h0000_1021);
    cpu.xfer(1'b1, 12'h00C, 32'h0000_0001);
    rd(12'h010, 33'h0_0000_0008);
    cpu.xfer(1'b1, 12'h014, 32'h0000_0001);
    cpu.run_cmd(8'h30, `FSPC_CMD_ERASE);
    rd(12'h010, 33'h0_0000_0000);
    cpu.xfer(1'b1, 12'h008, 32'h0000_005A);
    cpu.run_cmd(8'h40, `FSPC_CMD_WRITE);
    cpu.xfer(1'b1, 12'h000, 32'h0000_0000);
    chk_pin("irq_hold", 1'b0, irq_hold);
    chk_pin("pin_hold", 1'b0, pin_hold);
    // a command outside the mode must be ignored; the later verify of 0x40 shows it
    cpu.run_cmd(8'h40, `FSPC_CMD_ERASE);
    cpu.enter_mode();
    rd(12'h010, 33'h0_0000_0004);
    cpu.run_cmd(8'h40, `FSPC_CMD_ERASE);
    rd(12'h010, 33'h0_0000_0006);
    vfy(8'h40, 8'h5A);
    cpu.xfer(1'b1, 12'h008, 32'h0000_00A5);
    cpu.run_cmd(8'h40, `FSPC_CMD_WRITE);
    rd(12'h010, 33'h0_0000_0006);
    vfy(8'h40, 8'h5A);
    cpu.xfer(1'b1, 12'h008, 32'h0000_0050);
    cpu.run_cmd(8'h40, `FSPC_CMD_WRITE);
    rd(12'h010, 33'h0_0000_0006);
    vfy(8'h40, 8'h5A);
    cpu.xfer(1'b1, 12'h008, {24'h00_0000, byte_v});
    cpu.run_cmd(8'h41, `FSPC_CMD_WRITE);
    rd(12'h010, 33'h0_0000_0004);
    vfy(8'h41, byte_v);
    rd(12'h020, 33'h1_0000_0000);
    chk_pin("ram_req", 1'b0, ram_req);
    wrap_up();
  end
endmodule // fspc_top_tb_top
`default_nettype wire
